// file: shared/pmra_pkg.sv
// constants for the power monitor result and alert register bank
package pmra_pkg;
  // ==========================================================
  // register addresses
  localparam logic [7:0] ADDR_SHUNT_VOLTAGE_RESULT = 8'h04;
  localparam logic [7:0] ADDR_BUS_VOLTAGE_RESULT   = 8'h05;
  localparam logic [7:0] ADDR_DIE_TEMPERATURE      = 8'h06;
  localparam logic [7:0] ADDR_CURRENT_RESULT       = 8'h07;
  localparam logic [7:0] ADDR_POWER_RESULT         = 8'h08;
  localparam logic [7:0] ADDR_DIAG_ALERT_FLAGS     = 8'h0B;
  // ==========================================================
  // widths
  localparam int RESULT_W = 16;
  localparam int POWER_W  = 24;
  localparam int TEMP_W   = 12;
  localparam int TEMP_LSB = 4;
  localparam int PLIM_SH  = 8;
  // ==========================================================
  // diagnostic register bit positions
  localparam int BIT_LATCH      = 15;
  localparam int BIT_READY_EN   = 14;
  localparam int BIT_AVG_SEL    = 13;
  localparam int BIT_POLARITY   = 12;
  localparam int BIT_MATH_OF    = 9;
  localparam int BIT_TEMP_OL    = 7;
  localparam int BIT_SHUNT_OL   = 6;
  localparam int BIT_SHUNT_UL   = 5;
  localparam int BIT_BUS_OL     = 4;
  localparam int BIT_BUS_UL     = 3;
  localparam int BIT_POWER_OL   = 2;
  localparam int BIT_CONV_READY = 1;
  localparam int BIT_TRIM_OK    = 0;
  // ==========================================================
  // reset values
  localparam logic [15:0] RST_RESULT = 16'h0000;
  localparam logic [23:0] RST_POWER  = 24'h000000;
  localparam logic [11:0] RST_TEMP   = 12'h000;
  localparam logic [3:0]  TEMP_ZERO  = 4'h0;
  localparam logic        RST_TRIM   = 1'b1;
endpackage

// file: rtl/pmra_result_bank.sv
// result registers and diagnostic flag and alert logic of the power monitor
`timescale 1ns/100ps
module pmra_result_bank
  import pmra_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire logic                ce,
  // register port
  input  wire logic [7:0]          regAddr,
  input  wire logic                regRead,
  input  wire logic                regWrite,
  input  wire logic [15:0]         regWrData,
  output logic      [23:0]         regRdData,
  // raw converter samples
  input  wire logic                rawValid,
  input  wire logic [15:0]         rawShunt,
  input  wire logic [15:0]         rawBus,
  input  wire logic [11:0]         rawTemp,
  // completed (averaged) results
  input  wire logic                avgValid,
  input  wire logic [15:0]         avgShunt,
  input  wire logic [15:0]         avgBus,
  input  wire logic [11:0]         avgTemp,
  input  wire logic [15:0]         avgCurrent,
  input  wire logic [23:0]         avgPower,
  // engine events
  input  wire logic                mathOverflow,
  input  wire logic                triggerStart,
  input  wire logic                trimChecksumError,
  // thresholds
  input  wire logic [15:0]         shuntOverLimit,
  input  wire logic [15:0]         shuntUnderLimit,
  input  wire logic [14:0]         busOverLimit,
  input  wire logic [14:0]         busUnderLimit,
  input  wire logic [11:0]         tempOverLimit,
  input  wire logic [15:0]         powerOverLimit,
  // open-drain alert pin and registered alert echo
  output logic                     alertOut,
  output logic                     alertOe_n,
  output logic                     shuntRangeEcho
);

  // ==========================================================
  // state
  logic [15:0] shuntVoltageResult;
  logic [15:0] busVoltageResult;
  logic [11:0] dieTemperatureResult;
  logic [15:0] currentResult;
  logic [23:0] powerResult;
  logic        alertLatchEnable;
  logic        readyOnAlertEnable;
  logic        averagedCompareSelect;
  logic        alertPolarity;
  logic        mathOverflowFlag;
  logic        temperatureOverLimitFlag;
  logic        shuntOverLimitFlag;
  logic        shuntUnderLimitFlag;
  logic        busOverLimitFlag;
  logic        busUnderLimitFlag;
  logic        powerOverLimitFlag;
  logic        conversionReadyFlag;
  logic        trimMemoryOk;
  logic        alertActive;

  logic [15:0] next_shuntVoltageResult;
  logic [15:0] next_busVoltageResult;
  logic [11:0] next_dieTemperatureResult;
  logic [15:0] next_currentResult;
  logic [23:0] next_powerResult;
  logic        next_alertLatchEnable;
  logic        next_readyOnAlertEnable;
  logic        next_averagedCompareSelect;
  logic        next_alertPolarity;
  logic        next_mathOverflowFlag;
  logic        next_temperatureOverLimitFlag;
  logic        next_shuntOverLimitFlag;
  logic        next_shuntUnderLimitFlag;
  logic        next_busOverLimitFlag;
  logic        next_busUnderLimitFlag;
  logic        next_powerOverLimitFlag;
  logic        next_conversionReadyFlag;
  logic        next_trimMemoryOk;
  logic        next_alertActive;
  logic [23:0] next_regRdData;

  // ==========================================================
  // compare source and limit conditions
  logic        cmpValid;
  logic [15:0] cmpShunt;
  logic [15:0] cmpBus;
  logic [11:0] cmpTemp;
  logic        hitTemp;
  logic        hitShuntOver;
  logic        hitShuntUnder;
  logic        hitBusOver;
  logic        hitBusUnder;
  logic        hitPower;
  logic        diagRead;
  logic        diagWrite;
  logic [15:0] diagWord;

  // pick raw samples or averaged results for comparison
  always_comb begin
    cmpValid = averagedCompareSelect ? avgValid : rawValid;
    cmpShunt = averagedCompareSelect ? avgShunt : rawShunt;
    cmpBus   = averagedCompareSelect ? avgBus : rawBus;
    cmpTemp  = averagedCompareSelect ? avgTemp : rawTemp;
  end

  // threshold comparisons
  assign hitTemp       = $signed(cmpTemp) > $signed(tempOverLimit);
  assign hitShuntOver  = $signed(cmpShunt) > $signed(shuntOverLimit);
  assign hitShuntUnder = $signed(cmpShunt) < $signed(shuntUnderLimit);
  assign hitBusOver    = $signed(cmpBus) > $signed({1'b0, busOverLimit});
  assign hitBusUnder   = $signed(cmpBus) < $signed({1'b0, busUnderLimit});
  assign hitPower      = avgPower > {powerOverLimit, {PLIM_SH{1'b0}}};

  assign diagRead  = regRead && (regAddr == ADDR_DIAG_ALERT_FLAGS);
  assign diagWrite = regWrite && (regAddr == ADDR_DIAG_ALERT_FLAGS);

  // diagnostic word as the host sees it
  always_comb begin
    diagWord                 = 16'h0000;
    diagWord[BIT_LATCH]      = alertLatchEnable;
    diagWord[BIT_READY_EN]   = readyOnAlertEnable;
    diagWord[BIT_AVG_SEL]    = averagedCompareSelect;
    diagWord[BIT_POLARITY]   = alertPolarity;
    diagWord[BIT_MATH_OF]    = mathOverflowFlag;
    diagWord[BIT_TEMP_OL]    = temperatureOverLimitFlag;
    diagWord[BIT_SHUNT_OL]   = shuntOverLimitFlag;
    diagWord[BIT_SHUNT_UL]   = shuntUnderLimitFlag;
    diagWord[BIT_BUS_OL]     = busOverLimitFlag;
    diagWord[BIT_BUS_UL]     = busUnderLimitFlag;
    diagWord[BIT_POWER_OL]   = powerOverLimitFlag;
    diagWord[BIT_CONV_READY] = conversionReadyFlag;
    diagWord[BIT_TRIM_OK]    = trimMemoryOk;
  end

  // one limit flag: transparent follows compare, latched holds until read
  function automatic logic limitNext(
    input logic cur,
    input logic valid,
    input logic hit,
    input logic latched,
    input logic rd
  );
    logic v;
    v = cur;
    if (latched) begin
      if (rd) begin
        v = 1'b0;
      end
      if (valid && hit) begin
        v = 1'b1;  // set wins over the read clear
      end
    end else if (valid) begin
      v = hit;
    end
    return v;
  endfunction

  // ==========================================================
  // next-state logic
  always_comb begin
    next_shuntVoltageResult       = shuntVoltageResult;
    next_busVoltageResult         = busVoltageResult;
    next_dieTemperatureResult     = dieTemperatureResult;
    next_currentResult            = currentResult;
    next_powerResult              = powerResult;
    next_alertLatchEnable         = alertLatchEnable;
    next_readyOnAlertEnable       = readyOnAlertEnable;
    next_averagedCompareSelect    = averagedCompareSelect;
    next_alertPolarity            = alertPolarity;
    next_mathOverflowFlag         = mathOverflowFlag;
    next_conversionReadyFlag      = conversionReadyFlag;
    next_trimMemoryOk             = trimMemoryOk;
    next_regRdData                = regRdData;

    // results load only on a completed (averaged) result
    if (avgValid) begin
      next_shuntVoltageResult   = avgShunt;
      next_busVoltageResult     = avgBus;
      next_dieTemperatureResult = avgTemp;
      next_currentResult        = avgCurrent;
      next_powerResult          = avgPower;
    end

    // control bits written by the host
    if (diagWrite) begin
      next_alertLatchEnable      = regWrData[BIT_LATCH];
      next_readyOnAlertEnable    = regWrData[BIT_READY_EN];
      next_averagedCompareSelect = regWrData[BIT_AVG_SEL];
      next_alertPolarity         = regWrData[BIT_POLARITY];
    end

    // limit flags
    next_temperatureOverLimitFlag = limitNext(temperatureOverLimitFlag, cmpValid, hitTemp,
                                              alertLatchEnable, diagRead);
    next_shuntOverLimitFlag  = limitNext(shuntOverLimitFlag, cmpValid, hitShuntOver,
                                         alertLatchEnable, diagRead);
    next_shuntUnderLimitFlag = limitNext(shuntUnderLimitFlag, cmpValid, hitShuntUnder,
                                         alertLatchEnable, diagRead);
    next_busOverLimitFlag    = limitNext(busOverLimitFlag, cmpValid, hitBusOver,
                                         alertLatchEnable, diagRead);
    next_busUnderLimitFlag   = limitNext(busUnderLimitFlag, cmpValid, hitBusUnder,
                                         alertLatchEnable, diagRead);
    next_powerOverLimitFlag  = limitNext(powerOverLimitFlag, avgValid, hitPower,
                                         alertLatchEnable, diagRead);

    // overflow: cleared by a trigger, set wins
    if (triggerStart) begin
      next_mathOverflowFlag = 1'b0;
    end
    if (mathOverflow) begin
      next_mathOverflowFlag = 1'b1;
    end

    // conversion ready: cleared by trigger, or by read when latched
    if (triggerStart || (alertLatchEnable && diagRead)) begin
      next_conversionReadyFlag = 1'b0;
    end
    if (avgValid) begin
      next_conversionReadyFlag = 1'b1;
    end

    // trim memory health is sticky low
    if (trimChecksumError) begin
      next_trimMemoryOk = 1'b0;
    end

    // read data captured from pre-clear values
    if (regRead) begin
      unique case (regAddr)
        ADDR_SHUNT_VOLTAGE_RESULT: next_regRdData = {8'h00, shuntVoltageResult};
        ADDR_BUS_VOLTAGE_RESULT:   next_regRdData = {8'h00, busVoltageResult};
        ADDR_DIE_TEMPERATURE:
          next_regRdData = {8'h00, dieTemperatureResult, TEMP_ZERO};
        ADDR_CURRENT_RESULT:       next_regRdData = {8'h00, currentResult};
        ADDR_POWER_RESULT:         next_regRdData = powerResult;
        ADDR_DIAG_ALERT_FLAGS:     next_regRdData = {8'h00, diagWord};
        default:                   next_regRdData = 24'h000000;
      endcase
    end

    // alert from the flag values being registered
    next_alertActive = next_temperatureOverLimitFlag | next_shuntOverLimitFlag
                     | next_shuntUnderLimitFlag | next_busOverLimitFlag
                     | next_busUnderLimitFlag | next_powerOverLimitFlag
                     | (next_conversionReadyFlag & next_readyOnAlertEnable);
  end

  // ==========================================================
  // registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      shuntVoltageResult       <= RST_RESULT;
      busVoltageResult         <= RST_RESULT;
      dieTemperatureResult     <= RST_TEMP;
      currentResult            <= RST_RESULT;
      powerResult              <= RST_POWER;
      alertLatchEnable         <= 1'b0;
      readyOnAlertEnable       <= 1'b0;
      averagedCompareSelect    <= 1'b0;
      alertPolarity            <= 1'b0;
      mathOverflowFlag         <= 1'b0;
      temperatureOverLimitFlag <= 1'b0;
      shuntOverLimitFlag       <= 1'b0;
      shuntUnderLimitFlag      <= 1'b0;
      busOverLimitFlag         <= 1'b0;
      busUnderLimitFlag        <= 1'b0;
      powerOverLimitFlag       <= 1'b0;
      conversionReadyFlag      <= 1'b0;
      trimMemoryOk             <= RST_TRIM;
      alertActive              <= 1'b0;
      regRdData                <= RST_POWER;
    end else if (ce) begin
      shuntVoltageResult       <= next_shuntVoltageResult;
      busVoltageResult         <= next_busVoltageResult;
      dieTemperatureResult     <= next_dieTemperatureResult;
      currentResult            <= next_currentResult;
      powerResult              <= next_powerResult;
      alertLatchEnable         <= next_alertLatchEnable;
      readyOnAlertEnable       <= next_readyOnAlertEnable;
      averagedCompareSelect    <= next_averagedCompareSelect;
      alertPolarity            <= next_alertPolarity;
      mathOverflowFlag         <= next_mathOverflowFlag;
      temperatureOverLimitFlag <= next_temperatureOverLimitFlag;
      shuntOverLimitFlag       <= next_shuntOverLimitFlag;
      shuntUnderLimitFlag      <= next_shuntUnderLimitFlag;
      busOverLimitFlag         <= next_busOverLimitFlag;
      busUnderLimitFlag        <= next_busUnderLimitFlag;
      powerOverLimitFlag       <= next_powerOverLimitFlag;
      conversionReadyFlag      <= next_conversionReadyFlag;
      trimMemoryOk             <= next_trimMemoryOk;
      alertActive              <= next_alertActive;
      regRdData                <= next_regRdData;
    end
  end

  // ==========================================================
  // open-drain alert pin, driven low when pulled active
  logic pinLowDrive;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pinLowDrive <= 1'b0;
    end else if (ce) begin
      pinLowDrive <= next_alertActive ^ next_alertPolarity;
    end
  end

  // pin value is always low; the enable (active low) decides driving
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      alertOut       <= 1'b0;
      alertOe_n      <= 1'b1;
      shuntRangeEcho <= 1'b0;
    end else if (ce) begin
      alertOut       <= 1'b0;
      alertOe_n      <= ~pinLowDrive;
      shuntRangeEcho <= alertActive;
    end
  end

endmodule

// file: verification/pmra_result_bank_chk.sv
// concurrent checks on the result bank ports
`timescale 1ns/100ps
module pmra_result_bank_chk
  import pmra_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic [7:0]  regAddr,
  input wire logic        regRead,
  input wire logic [23:0] regRdData,
  input wire logic        avgValid,
  input wire logic [15:0] avgCurrent,
  input wire logic [23:0] avgPower,
  input wire logic        mathOverflow,
  input wire logic        triggerStart,
  input wire logic        trimChecksumError,
  input wire logic        alertOut,
  input wire logic        alertOe_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // taken read of the diagnostic register
  sequence diagRd;
    ce && regRead && regAddr == ADDR_DIAG_ALERT_FLAGS;
  endsequence
  // ==========================================================
  // read data, flag and pin checks
  a_temp_low_zero: assert property (
    ce && regRead && regAddr == ADDR_DIE_TEMPERATURE |=> regRdData[3:0] == 4'h0)
    else $error("temperature low bits not zero");
  a_diag_reserved: assert property (
    diagRd |=> regRdData[11:10] == 2'h0 && !regRdData[8] && regRdData[23:16] == 8'h00)
    else $error("reserved diagnostic bits not zero");
  a_current_load: assert property (
    ce && avgValid ##1 !(ce && avgValid) ##1 ce && regRead && regAddr == ADDR_CURRENT_RESULT
    |=> regRdData == {8'h00, $past(avgCurrent, 3)}) else $error("current not loaded");
  a_power_load: assert property (
    ce && avgValid ##1 !(ce && avgValid) ##1 ce && regRead && regAddr == ADDR_POWER_RESULT
    |=> regRdData == $past(avgPower, 3)) else $error("power not loaded");
  a_ready_sets: assert property (
    ce && avgValid ##1 !triggerStart && !regRead ##1 diagRd |=> regRdData[1])
    else $error("ready flag not set");
  a_overflow_sets: assert property (
    ce && mathOverflow ##1 !triggerStart ##1 diagRd |=> regRdData[9])
    else $error("overflow flag not set");
  a_trigger_clears: assert property (
    ce && triggerStart && !mathOverflow && !avgValid ##1 !mathOverflow && !avgValid
    ##1 diagRd |=> !regRdData[9] && !regRdData[1]) else $error("trigger did not clear flags");
  a_trim_drop: assert property (
    ce && trimChecksumError ##[1:2] diagRd |=> !regRdData[0]) else $error("trim bit not cleared");
  a_pin_open_drain: assert property (
    alertOut == 1'b0) else $error("alert pin driven high");
  a_read_hold: assert property (
    !(ce && regRead) |=> $stable(regRdData)) else $error("read data changed without read");
  // ==========================================================
  // main scenarios reached
  c_diag_read: cover property (diagRd);
  c_alert_driven: cover property (!alertOe_n);
  c_overflow: cover property (ce && mathOverflow ##2 diagRd);
endmodule

bind pmra_result_bank pmra_result_bank_chk chk_u (
  .sys_clk, .rst, .ce, .regAddr, .regRead, .regRdData, .avgValid, .avgCurrent,
  .avgPower, .mathOverflow, .triggerStart, .trimChecksumError, .alertOut, .alertOe_n
);

// file: verification/pmra_host_model.sv
// register port host model issuing reads and writes
`timescale 1ns/100ps
module pmra_host_model (
  input  wire logic        sys_clk,
  output logic [7:0]       regAddr,
  output logic             regRead,
  output logic             regWrite,
  output logic [15:0]      regWrData,
  input  wire logic [23:0] regRdData
);
  // idle bus at time zero
  initial begin
    regAddr = 8'h00;
    regRead = 1'b0;
    regWrite = 1'b0;
    regWrData = 16'h0000;
  end
  // one-cycle read strobe, data registered one edge later
  task automatic rd(input logic [7:0] a, output logic [23:0] d);
    @(posedge sys_clk);
    #1;
    regAddr = a;
    regRead = 1'b1;
    @(posedge sys_clk);
    #1;
    regRead = 1'b0;
    regAddr = ~a;
    d = regRdData;
  endtask
  // one-cycle write strobe, data line inverted after release
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge sys_clk);
    #1;
    regAddr = a;
    regWrData = v;
    regWrite = 1'b1;
    @(posedge sys_clk);
    #1;
    regWrite = 1'b0;
    regAddr = ~a;
    regWrData = ~v;
  endtask
endmodule

// file: verification/pmra_result_bank_tb.sv
// self-checking bench for the result and alert register bank
`timescale 1ns/100ps
module pmra_result_bank_tb
  import pmra_pkg::*;
();
  logic        sys_clk, rst, ce, rawValid, avgValid, mathOverflow, triggerStart;
  logic        trimChecksumError, regRead, regWrite, alertOut, alertOe_n, shuntRangeEcho;
  logic [7:0]  regAddr;
  logic [15:0] regWrData, rawShunt, rawBus, avgShunt, avgBus, avgCurrent;
  logic [15:0] shuntOverLimit, shuntUnderLimit, powerOverLimit;
  logic [14:0] busOverLimit, busUnderLimit;
  logic [11:0] rawTemp, avgTemp, tempOverLimit;
  logic [23:0] regRdData, avgPower, rdv;
  int          num_errors = 0;
  int          n_checks = 0;
  int          cycles = 0;
  localparam logic [4:0] RV = 5'h10, AV = 5'h08, MO = 5'h04, TS = 5'h02, TC = 5'h01;
  localparam logic [7:0] ADDR_TAB [8] = '{ADDR_SHUNT_VOLTAGE_RESULT, ADDR_BUS_VOLTAGE_RESULT,
    ADDR_DIE_TEMPERATURE, ADDR_CURRENT_RESULT, ADDR_POWER_RESULT, ADDR_DIAG_ALERT_FLAGS,
    8'h00, 8'h0A};
  localparam logic [23:0] RES_TAB [8] = '{24'h008001, 24'h001234, 24'h00ABC0, 24'h00FEDC,
    24'hABCE00, 24'h000003, 24'h000000, 24'h000000};
  localparam logic [15:0] SH_TAB [6] = '{16'h0101, 16'hFEFF, 16'h0000, 16'h0000, 16'h0000, 16'h0100};
  localparam logic [15:0] BU_TAB [6] = '{16'h0800, 16'h0800, 16'h1001, 16'h00FF, 16'h0800, 16'h0800};
  localparam logic [11:0] TP_TAB [6] = '{12'h000, 12'h000, 12'h000, 12'h000, 12'h101, 12'h100};
  localparam logic [23:0] FL_TAB [6] = '{24'h000041, 24'h000021, 24'h000011, 24'h000009,
    24'h000081, 24'h000001};
  // ==========================================================
  // design and host
  pmra_result_bank dut_u (
    .sys_clk, .rst, .ce, .regAddr, .regRead, .regWrite, .regWrData, .regRdData,
    .rawValid, .rawShunt, .rawBus, .rawTemp, .avgValid, .avgShunt, .avgBus, .avgTemp,
    .avgCurrent, .avgPower, .mathOverflow, .triggerStart, .trimChecksumError,
    .shuntOverLimit, .shuntUnderLimit, .busOverLimit, .busUnderLimit, .tempOverLimit,
    .powerOverLimit, .alertOut, .alertOe_n, .shuntRangeEcho
  );
  pmra_host_model host_u (.sys_clk, .regAddr, .regRead, .regWrite, .regWrData, .regRdData);
  // ==========================================================
  // clock and hang guard
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles > 3000) begin
      num_errors++;
      print_verdict();
    end
  end
  // ==========================================================
  // shared tasks
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [23:0] exp);
    host_u.rd(a, rdv);
    check(rdv, exp);
  endtask
  task automatic pinchk(input logic exp);
    check({23'h0, alertOe_n}, {23'h0, exp});
  endtask
  task automatic strobe(input logic [4:0] s);
    @(posedge sys_clk);
    #1;
    {rawValid, avgValid, mathOverflow, triggerStart, trimChecksumError} = s;
    @(posedge sys_clk);
    #1;
    {rawValid, avgValid, mathOverflow, triggerStart, trimChecksumError} = 5'h00;
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    ce = 1'b1;
    rst = 1'b1;
    {rawValid, avgValid, mathOverflow, triggerStart, trimChecksumError} = 5'h00;
    {rawShunt, rawBus, rawTemp} = {16'h0000, 16'h0800, 12'h000};
    {avgShunt, avgBus, avgTemp, avgCurrent, avgPower} = '0;
    {shuntOverLimit, shuntUnderLimit} = {16'h0100, 16'hFF00};
    {busOverLimit, busUnderLimit} = {15'h1000, 15'h0100};
    {tempOverLimit, powerOverLimit} = {12'h100, 16'hABCE};
    repeat (3) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    foreach (ADDR_TAB[i]) rdchk(ADDR_TAB[i], (i == 5) ? 24'h000001 : 24'h000000);
    // control bits writable, reserved read zero, idle pin inverted
    host_u.wr(ADDR_DIAG_ALERT_FLAGS, 16'hFFFF);
    rdchk(ADDR_DIAG_ALERT_FLAGS, 24'h00F001);
    pinchk(1'b0);
    host_u.wr(ADDR_DIAG_ALERT_FLAGS, 16'h0000);
    // result load, raw samples leave results alone
    {avgShunt, avgBus, avgTemp} = {16'h8001, 16'h1234, 12'hABC};
    {avgCurrent, avgPower} = {16'hFEDC, 24'hABCE00};
    strobe(AV);
    strobe(RV);
    foreach (RES_TAB[i]) rdchk(ADDR_TAB[i], RES_TAB[i]);
    rdchk(ADDR_DIAG_ALERT_FLAGS, 24'h000003);
    strobe(TS);
    rdchk(ADDR_DIAG_ALERT_FLAGS, 24'h000001);
    // ready flag routed to the pin
    host_u.wr(ADDR_DIAG_ALERT_FLAGS, 16'h4000);
    strobe(AV);
    rdchk(ADDR_CURRENT_RESULT, 24'h00FEDC);
    rdchk(ADDR_DIAG_ALERT_FLAGS, 24'h004003);
    pinchk(1'b0);
    host_u.wr(ADDR_DIAG_ALERT_FLAGS, 16'h5000);
    rdchk(ADDR_DIAG_ALERT_FLAGS, 24'h005003);
    pinchk(1'b1);
    host_u.wr(ADDR_DIAG_ALERT_FLAGS, 16'h0000);
    rdchk(ADDR_DIAG_ALERT_FLAGS, 24'h000003);
    pinchk(1'b1);
    strobe(TS);
    // raw limit compares, transparent mode
    for (int i = 0; i < 6; i++) begin
      {rawShunt, rawBus, rawTemp} = {SH_TAB[i], BU_TAB[i], TP_TAB[i]};
      strobe(RV);
      rdchk(ADDR_DIAG_ALERT_FLAGS, FL_TAB[i]);
      pinchk(FL_TAB[i] == 24'h000001);
      check({23'h0, shuntRangeEcho}, {23'h0, FL_TAB[i] != 24'h000001});
      {rawShunt, rawBus, rawTemp} = {16'h0000, 16'h0800, 12'h000};
      strobe(RV);
      rdchk(ADDR_DIAG_ALERT_FLAGS, 24'h000001);
    end
    // averaged compare select
    host_u.wr(ADDR_DIAG_ALERT_FLAGS, 16'h2000);
    rawShunt = 16'h0101;
    strobe(RV);
    rdchk(ADDR_DIAG_ALERT_FLAGS, 24'h002001);
    {avgShunt, avgBus} = {16'h0101, 16'h0800};
    strobe(AV);
    rdchk(ADDR_DIAG_ALERT_FLAGS, 24'h002043);
    pinchk(1'b0);
    {rawShunt, avgShunt} = 32'h0;
    host_u.wr(ADDR_DIAG_ALERT_FLAGS, 16'h0000);
    strobe(RV | TS);
    // latched mode, clear on read after capture
    host_u.wr(ADDR_DIAG_ALERT_FLAGS, 16'h8000);
    rawShunt = 16'h0101;
    strobe(RV);
    rawShunt = 16'h0000;
    strobe(RV);
    rdchk(ADDR_DIAG_ALERT_FLAGS, 24'h008041);
    rdchk(ADDR_DIAG_ALERT_FLAGS, 24'h008001);
    powerOverLimit = 16'hABCD;
    strobe(AV);
    rdchk(ADDR_POWER_RESULT, 24'hABCE00);
    rdchk(ADDR_DIAG_ALERT_FLAGS, 24'h008007);
    rdchk(ADDR_DIAG_ALERT_FLAGS, 24'h008001);
    // overflow survives reads, trigger clears it
    strobe(MO);
    rdchk(ADDR_DIAG_ALERT_FLAGS, 24'h008201);
    rdchk(ADDR_DIAG_ALERT_FLAGS, 24'h008201);
    strobe(TS);
    rdchk(ADDR_DIAG_ALERT_FLAGS, 24'h008001);
    // trim error, then signed temperature limit
    strobe(TC);
    rdchk(ADDR_DIAG_ALERT_FLAGS, 24'h008000);
    tempOverLimit = 12'hF00;
    strobe(RV);
    rdchk(ADDR_DIAG_ALERT_FLAGS, 24'h008080);
    print_verdict();
  end
endmodule
